// file: rtl/_unused_placeholder_none.sv
// Intentionally empty file slot not used
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: rtl/supmon_ctrl.sv
// Supply monitor control: modes, sleep, low-voltage reset, register
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Two control bits select off, periodic, continuous
// - Continuous bit reads busy in both modes
// - Sleep waits for conversion, clears both bits
// - Result latched, held until next conversion
// - Conversion 7.8 ms; early read gives old
// - Result is plain binary level 0..15
// - Continuous: tick-aligned, 16 ticks, back to back
// - Clearing continuous finishes current conversion first
// - Periodic: one conversion every four seconds
// - Clearing periodic finishes conversion; busy only converting
// - Four level-0 results force continuous, reset
// - Reset held until level two or above
// - Release restores the earlier sampling mode
// - One hardware conversion after reset, busy shown
// - Reset and sleep clear both control bits
// - Level D0-D3, continuous D4, periodic D5
module supmon_ctrl #(
  parameter logic        LVR_ENABLE   = 1'b1,                         // Low-voltage reset option
  parameter logic [13:0] PERIOD_TICKS = supmon_pkg::PERIOD_TICKS_DEF  // Ticks per period
) (
  input  wire logic                        clk_sys,           // System clock
  input  wire logic                        rst,               // Async reset, high
  input  wire supmon_pkg::supmon_bus_req_t bus,               // Register request
  output var  logic [7:0]                  rdata,             // Read data, next cycle
  input  wire logic                        osc_in,            // Low-speed oscillator pin
  input  wire logic                        comp_in,           // Comparator pin
  input  wire logic                        sleep_instruction, // Sleep executed, level
  output var  supmon_pkg::supmon_afe_t     afe,               // Front end controls
  output var  logic                        osc_stop_ok,       // Oscillator may stop
  output var  logic                        lvr_reset          // Internal initial reset
);
  import supmon_pkg::*;

  // Agreement filter behind the three-stage synchronisers
  function automatic logic sync_agree(
    input logic s2,
    input logic s3,
    input logic cur
  );
    sync_agree = (s2 == s3) ? s3 : cur;
  endfunction : sync_agree

  // Pin synchronisers
  logic [2:0]  osc_sync;     // Oscillator stages
  logic        osc_filt;     // Filtered oscillator
  logic        osc_prev;     // Previous filtered value
  logic [2:0]  comp_sync;    // Comparator stages
  logic        comp_filt;    // Filtered comparator

  // Divider state
  logic [3:0]  div_cnt;      // Oscillator edges per tick
  logic        tick;         // 2,048 Hz tick pulse
  logic [13:0] period_cnt;   // Ticks within period

  // Control state
  logic        cont_ctrl;    // Continuous control bit
  logic        per_ctrl;     // Periodic control bit
  logic        init_pending; // First sample still owed
  supmon_pwr_t pwr;          // Sleep handling state
  supmon_pwr_t next_pwr;     // Next sleep state
  logic        sleep_prev;   // Sleep input last cycle

  // Low-voltage reset state
  logic [2:0]  zero_cnt;     // Consecutive zero results
  logic        saved_cont;   // Continuous bit before trip
  logic        saved_per;    // Periodic bit before trip

  // Converter handshake
  logic        conv_busy;    // Conversion running
  logic        conv_done;    // Result latched pulse
  logic [3:0]  level;        // Latched level

  // Oscillator edge and tick decode
  wire osc_rise   = osc_filt & ~osc_prev;
  wire div_wrap   = (div_cnt == OSC_DIV_LAST);
  wire period_end = (period_cnt == (PERIOD_TICKS - 14'h1));

  // The periodic trigger is only meaningful on a tick
  wire period_hit = tick & period_end;

  // Register decode
  wire reg_sel = (bus.addr == SUPMON_REG_ADDR);
  wire is_run  = (pwr == PWR_RUN);

  // Writes are ignored while sleep is pending or active
  wire wr_hit  = bus.wr & reg_sel & is_run;
  wire rd_hit  = bus.rd & reg_sel;

  // Busy reads through the continuous bit, also while the first sample is owed
  wire busy_view = cont_ctrl | conv_busy | init_pending;

  // Status byte; the two top bits are always zero
  wire [7:0] status_byte = {2'b00, per_ctrl, busy_view, level};

  // Mode selection: continuous wins over periodic
  wire want_cont = cont_ctrl | lvr_reset;
  wire want_per  = per_ctrl & ~cont_ctrl & period_hit;

  // New conversions only run while running; a start in the sleep edge cycle
  // would power the front end just as the oscillator is released
  wire may_start = is_run & ~sleep_instruction;

  // Start or continue request seen by the converter
  wire start_req = may_start & (want_cont | want_per | init_pending);

  // A fresh conversion is accepted on an idle tick
  wire start_take = tick & ~conv_busy & start_req;

  // Sleep entry from the instruction edge
  wire sleep_rise  = sleep_instruction & ~sleep_prev;
  wire sleep_enter = is_run & sleep_rise;

  // Low-voltage reset decode
  wire got_zero    = conv_done & (level == LEVEL_ZERO);
  wire lvr_trip    = LVR_ENABLE & got_zero & ~lvr_reset &
                     (zero_cnt == LVR_ZERO_LAST);
  wire lvr_release = lvr_reset & conv_done &
                     (level >= LVR_RELEASE);

  // Oscillator and comparator synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_sync  <= 3'h0;
      osc_filt  <= 1'b0;
      osc_prev  <= 1'b0;
      comp_sync <= 3'h0;
      comp_filt <= 1'b0;
    end else begin
      // Stage 0 only feeds stage 1
      osc_sync  <= {osc_sync[1:0], osc_in};
      osc_filt  <= sync_agree(osc_sync[1], osc_sync[2], osc_filt);
      osc_prev  <= osc_filt;
      comp_sync <= {comp_sync[1:0], comp_in};
      comp_filt <= sync_agree(comp_sync[1], comp_sync[2], comp_filt);
    end
  end

  // Tick divider; runs free so conversions stay tick-aligned
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_cnt <= 4'h0;
      tick    <= 1'b0;
    end else begin
      tick <= osc_rise & div_wrap;
      if (osc_rise) begin
        div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
      end
    end
  end

  // Period counter; wraps every four seconds of ticks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      period_cnt <= 14'h0;
    end else if (tick) begin
      period_cnt <= period_end ? 14'h0 : period_cnt + 14'h1;
    end
  end

  // Next sleep state
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      PWR_RUN: begin
        if (sleep_rise) begin
          // Hold the oscillator while a sample is in flight
          next_pwr = conv_busy ? PWR_WAIT : PWR_SLEEP;
        end
      end
      PWR_WAIT: begin
        if (!conv_busy) begin
          next_pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (!sleep_instruction) begin
          next_pwr = PWR_RUN;
        end
      end
      default: begin
        // Illegal code falls back to running
        next_pwr = PWR_RUN;
      end
    endcase
  end

  // Sleep state and oscillator release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr         <= PWR_RUN;
      sleep_prev  <= 1'b0;
      osc_stop_ok <= 1'b0;
    end else begin
      pwr         <= next_pwr;
      sleep_prev  <= sleep_instruction;
      osc_stop_ok <= (next_pwr == PWR_SLEEP);
    end
  end

  // Control bits: sleep clears, release restores, else software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cont_ctrl <= CONT_RST;
      per_ctrl  <= PER_RST;
    end else if (sleep_enter) begin
      cont_ctrl <= 1'b0;
      per_ctrl  <= 1'b0;
    end else if (lvr_release) begin
      cont_ctrl <= saved_cont;
      per_ctrl  <= saved_per;
    end else if (wr_hit) begin
      // Clearing a bit never cuts a conversion short
      cont_ctrl <= bus.wdata[CONT_BIT];
      per_ctrl  <= bus.wdata[PER_BIT];
    end
  end

  // First hardware sample after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      init_pending <= INIT_RST;
    end else if (start_take) begin
      init_pending <= 1'b0;
    end
  end

  // Zero-run counter and forced-reset latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      zero_cnt   <= 3'h0;
      lvr_reset  <= 1'b0;
      saved_cont <= CONT_RST;
      saved_per  <= PER_RST;
    end else begin
      if (lvr_trip || (conv_done && !got_zero)) begin
        zero_cnt <= 3'h0;
      end else if (got_zero && zero_cnt != LVR_ZERO_LAST) begin
        zero_cnt <= zero_cnt + 3'h1;
      end
      if (lvr_trip) begin
        // Keep the mode so release can put it back
        lvr_reset  <= 1'b1;
        saved_cont <= cont_ctrl;
        saved_per  <= per_ctrl;
      end else if (lvr_release) begin
        lvr_reset  <= 1'b0;
      end
    end
  end

  // Read data stands for one cycle, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_hit ? status_byte : 8'h00;
    end
  end

  // Converter; results come back with the done pulse
  supmon_sar u_sar (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .tick       (tick),
    .start_req  (start_req),
    .comp_above (comp_filt),
    .busy       (conv_busy),
    .done       (conv_done),
    .result     (level),
    .afe        (afe)
  );

endmodule : supmon_ctrl
`default_nettype wire

// file: rtl/supmon_pkg.sv
// Constants and types shared by the supply monitor control block
package supmon_pkg;

  // Register map and field layout
  localparam logic [15:0] SUPMON_REG_ADDR = 16'hFF12; // Control/status byte
  localparam int unsigned LEVEL_LSB       = 0;        // Level field low bit
  localparam int unsigned LEVEL_MSB       = 3;        // Level field high bit
  localparam int unsigned CONT_BIT        = 4;        // Continuous ctrl/busy
  localparam int unsigned PER_BIT         = 5;        // Periodic ctrl

  // Values after reset
  localparam logic       CONT_RST  = 1'b0; // Continuous bit
  localparam logic       PER_RST   = 1'b0; // Periodic bit
  localparam logic [3:0] LEVEL_RST = 4'h0; // Result before first sample
  localparam logic       INIT_RST  = 1'b1; // First sample pending

  // Timing of the low-speed side
  localparam int unsigned OSC_FREQ_HZ  = 32768; // Low-speed oscillator
  localparam int unsigned TICK_FREQ_HZ = 2048;  // Conversion tick
  localparam logic [3:0]  OSC_DIV_LAST = 4'((OSC_FREQ_HZ / TICK_FREQ_HZ) - 1);
  localparam int unsigned CONV_TIME_US = 7800;  // One conversion
  localparam int unsigned CONV_TICKS   = (CONV_TIME_US * TICK_FREQ_HZ + 999999) / 1000000;
  localparam logic [3:0]  CONV_LAST    = 4'(CONV_TICKS - 1);
  localparam int unsigned PERIOD_S     = 4;     // Periodic interval
  localparam logic [13:0] PERIOD_TICKS_DEF = 14'(PERIOD_S * TICK_FREQ_HZ);

  // Converter and low-voltage reset values
  localparam logic [3:0] SAR_INIT       = 4'h8; // First trial code
  localparam logic [3:0] LEVEL_ZERO     = 4'h0; // Lowest level
  localparam logic [3:0] LVR_RELEASE    = 4'h2; // Recovery level
  localparam logic [2:0] LVR_ZERO_LAST  = 3'h3; // Fourth zero trips

  // Register port request
  typedef struct packed {
    logic [15:0] addr;  // Byte address
    logic [7:0]  wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } supmon_bus_req_t;

  // Analog front end controls
  typedef struct packed {
    logic       en;    // Front end powered
    logic [3:0] trial; // Trial code for comparator
  } supmon_afe_t;

  // Sleep handling states
  typedef enum logic [2:0] {
    PWR_RUN   = 3'b001,
    PWR_WAIT  = 3'b010,
    PWR_SLEEP = 3'b100
  } supmon_pwr_t;

  // Converter states
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_BUSY = 2'b10
  } supmon_conv_t;

endpackage : supmon_pkg

// file: rtl/supmon_sar.sv
// Successive-approximation sequencer for the supply monitor
`timescale 1ns/1ps
`default_nettype none
module supmon_sar (
  input  wire logic              clk_sys,    // System clock
  input  wire logic              rst,        // Async reset, high
  input  wire logic              tick,       // Conversion tick pulse
  input  wire logic              start_req,  // Start/continue request
  input  wire logic              comp_above, // Supply above trial
  output var  logic              busy,       // Conversion running
  output var  logic              done,       // Result latched pulse
  output var  logic [3:0]        result,     // Latched level
  output var  supmon_pkg::supmon_afe_t afe   // Front end controls
);
  import supmon_pkg::*;

  supmon_conv_t state;     // Converter state
  logic [3:0]   step;      // Tick within conversion
  logic [3:0]   trial;     // Current trial code

  // One bit is decided every fourth tick, high bit first
  wire       decide   = (step[1:0] == 2'h3);
  wire [1:0] bit_sel  = 2'h3 - step[3:2];
  wire [3:0] bit_mask = 4'h1 << bit_sel;
  wire [3:0] kept     = comp_above ? trial : (trial & ~bit_mask);
  wire [3:0] next_trial = decide ? (kept | (bit_mask >> 1)) : trial;

  assign afe = '{en: busy, trial: trial};

  // Sequencer; result only moves at the end so reads see the old one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state  <= CONV_IDLE;
      busy   <= 1'b0;
      done   <= 1'b0;
      step   <= 4'h0;
      trial  <= SAR_INIT;
      result <= LEVEL_RST;
    end else begin
      done <= 1'b0;
      unique case (state)
        CONV_IDLE: begin
          if (tick && start_req) begin
            state <= CONV_BUSY;
            busy  <= 1'b1;
            step  <= 4'h0;
            trial <= SAR_INIT;
          end
        end
        CONV_BUSY: begin
          if (tick && step == CONV_LAST) begin
            result <= kept;
            done   <= 1'b1;
            step   <= 4'h0;
            trial  <= SAR_INIT;
            if (!start_req) begin
              state <= CONV_IDLE;
              busy  <= 1'b0;
            end
          end else if (tick) begin
            step  <= step + 4'h1;
            trial <= next_trial;
          end
        end
      endcase
    end
  end

endmodule : supmon_sar
`default_nettype wire

// file: tb/supmon_afe_model.sv
// Behavioural comparator and reference front end
`timescale 1ns/1ps
`default_nettype none
module supmon_afe_model (
  input  wire logic                    clk_sys, // Clock
  input  wire supmon_pkg::supmon_afe_t afe,     // Front end controls
  input  wire logic [3:0]              supply,  // Level to report
  output var  logic                    comp_in  // Comparator output
);
  initial comp_in = 1'b0;
  // Unpowered front end toggles, so a stale answer is never seen
  always @(posedge clk_sys) begin
    if (afe.en) begin
      comp_in <= (supply >= afe.trial);
    end else begin
      comp_in <= ~comp_in;
    end
  end
endmodule : supmon_afe_model
`default_nettype wire

// file: tb/supmon_checker.sv
// Port assertions for the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module supmon_checker (
  input wire logic                        clk_sys,           // Clock
  input wire logic                        rst,               // Reset
  input wire supmon_pkg::supmon_bus_req_t bus,               // Requests
  input wire logic [7:0]                  rdata,             // Read data
  input wire logic                        sleep_instruction, // Sleep level
  input wire supmon_pkg::supmon_afe_t     afe,               // Front end
  input wire logic                        osc_stop_ok,       // Stop grant
  input wire logic                        lvr_reset          // Low-voltage reset
);
  import supmon_pkg::*;
  // Holds only for a bench oscillator of eight clocks per period
  localparam int CONV_CLKS = 2048;
  logic [15:0] run_len;                                  // Cycles front end on
  wire         hit = bus.rd && (bus.addr == SUPMON_REG_ADDR); // Mapped read
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Length of the current powered run
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_len <= 16'h0000;
    end else begin
      run_len <= afe.en ? run_len + 16'h0001 : 16'h0000;
    end
  end
  AST_RD_IDLE: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not zero without a read");
  AST_RD_UNMAP: assert property ($past(bus.rd) && $past(bus.addr) != SUPMON_REG_ADDR |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_TOP_ZERO: assert property (rdata[7:6] == 2'b00)
    else $error("upper bits not zero");
  AST_BUSY_D4: assert property ($past(hit) && $past(afe.en, 2) && $past(afe.en) |-> rdata[4])
    else $error("busy not shown on bit 4");
  AST_TRIAL_START: assert property ($rose(afe.en) |-> afe.trial == SAR_INIT)
    else $error("conversion not started at first trial");
  AST_CONV_LEN: assert property ($fell(afe.en) |-> run_len % CONV_CLKS == 0)
    else $error("conversion run not whole conversions");
  AST_STOP_IDLE: assert property (osc_stop_ok |-> !afe.en)
    else $error("oscillator stop during conversion");
  AST_SLEEP_CLR: assert property ($rose(sleep_instruction) ##2 hit |=> !rdata[5])
    else $error("periodic bit kept in sleep");
endmodule : supmon_checker
bind supmon_ctrl supmon_checker u_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
  .sleep_instruction(sleep_instruction), .afe(afe), .osc_stop_ok(osc_stop_ok), .lvr_reset(lvr_reset));
`default_nettype wire

// file: tb/supmon_ctrl_tb.sv
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module supmon_ctrl_tb;
  import supmon_pkg::*;
  localparam int TICK = 128;       // Clocks per tick
  localparam int CONV = 16 * TICK; // Clocks per conversion
  logic            clk_sys = 1'b0, rst = 1'b1, osc_in = 1'b0, sleep_instruction = 1'b0;
  logic            comp_in, osc_stop_ok, lvr_reset, rd_d = 1'b0, en_d = 1'b0;
  logic [3:0]      supply = 4'hA, lv;
  logic [7:0]      rdata;
  supmon_bus_req_t bus = '0;
  supmon_afe_t     afe;
  logic [15:0]     q_exp[$];       // Mask and expected byte
  int              mismatches = 0, n_checks = 0, cyc = 0, n_rise = 0, seed = 77, t0, t1;
  always #2 clk_sys = ~clk_sys;
  // Oscillator of eight clocks per period, edges away from clk rises
  always #16 osc_in = ~osc_in;
  supmon_ctrl #(.LVR_ENABLE(1'b1), .PERIOD_TICKS(14'h0020)) dut (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .rdata(rdata), .osc_in(osc_in), .comp_in(comp_in), .sleep_instruction(sleep_instruction), .afe(afe),
    .osc_stop_ok(osc_stop_ok), .lvr_reset(lvr_reset));
  supmon_afe_model u_afe (.clk_sys(clk_sys), .afe(afe), .supply(supply), .comp_in(comp_in));
  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : check_byte
  task automatic check_cnt(input string n, input int e, input int g);
    n_checks++;
    if (g != e) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask : check_cnt
  task automatic reg_wr(input logic [7:0] d);
    bus <= '{addr: SUPMON_REG_ADDR, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask : reg_wr
  // Notes the masked expectation, then issues the read
  task automatic reg_rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    q_exp.push_back({m, e & m});
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask : reg_rd
  // Bounded wait on front end power or low-voltage reset
  task automatic wait_sig(input logic lvr, input logic v, output int t);
    int n;
    n = 0;
    while ((lvr ? lvr_reset : afe.en) !== v && n < 24000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 24000) mismatches++;
    t = cyc;
  endtask : wait_sig
  // Cycle count, conversion starts and the overall limit
  always @(posedge clk_sys) begin
    rd_d <= bus.rd;
    en_d <= afe.en;
    cyc  <= cyc + 1;
    if (en_d === 1'b0 && afe.en === 1'b1) n_rise <= n_rise + 1;
    if (cyc == 90000) begin
      mismatches++;
      give_verdict();
    end
  end
  // Read data is settled by the falling edge after the answer edge
  always @(negedge clk_sys) begin : mon
    logic [15:0] e;
    if (rd_d === 1'b1) begin
      e = q_exp.pop_front();
      check_byte("rdata", e[7:0], rdata & e[15:8]);
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    reg_rd(SUPMON_REG_ADDR, 8'hF0, 8'h10);
    reg_rd(16'hFF13, 8'hFF, 8'h00);
    wait_sig(1'b0, 1'b1, t0);
    reg_rd(SUPMON_REG_ADDR, 8'h10, 8'h10);
    wait_sig(1'b0, 1'b0, t1);
    check_cnt("first_len", CONV, t1 - t0);
    reg_rd(SUPMON_REG_ADDR, 8'hFF, 8'h0A);
    // Continuous: two back-to-back conversions, then cleared mid-run
    lv = 4'(32'd2 + {$random(seed)} % 32'd14);
    supply <= lv;
    reg_wr(8'h10);
    wait_sig(1'b0, 1'b1, t0);
    repeat (CONV + 64) @(posedge clk_sys);
    reg_rd(SUPMON_REG_ADDR, 8'hFF, {4'h1, lv});
    reg_wr(8'h00);
    reg_rd(SUPMON_REG_ADDR, 8'h10, 8'h10);
    wait_sig(1'b0, 1'b0, t1);
    check_cnt("cont_len", 2 * CONV, t1 - t0);
    reg_rd(SUPMON_REG_ADDR, 8'hFF, {4'h0, lv});
    // Periodic: busy only while converting, one start per period
    lv = 4'(32'd2 + {$random(seed)} % 32'd14);
    supply <= lv;
    reg_wr(8'h20);
    wait_sig(1'b0, 1'b1, t0);
    wait_sig(1'b0, 1'b0, t1);
    check_cnt("per_len", CONV, t1 - t0);
    reg_rd(SUPMON_REG_ADDR, 8'hFF, {4'h2, lv});
    wait_sig(1'b0, 1'b1, t1);
    check_cnt("per_gap", 32 * TICK, t1 - t0);
    reg_wr(8'h00);
    wait_sig(1'b0, 1'b0, t0);
    check_cnt("per_stop", CONV, t0 - t1);
    // Sleep in mid-conversion: bits cleared, stop waits for the end
    reg_wr(8'h30);
    wait_sig(1'b0, 1'b1, t0);
    sleep_instruction <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reg_rd(SUPMON_REG_ADDR, 8'h30, 8'h10);
    wait_sig(1'b0, 1'b0, t1);
    check_cnt("sleep_len", CONV, t1 - t0);
    repeat (2) @(posedge clk_sys);
    check_byte("osc_stop_ok", 8'h01, {7'h00, osc_stop_ok});
    reg_wr(8'h10);
    sleep_instruction <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reg_rd(SUPMON_REG_ADDR, 8'hFF, {4'h0, lv});
    // Low-voltage reset from periodic mode, level 1 holds, level 3 frees
    supply <= 4'h0;
    reg_wr(8'h20);
    t0 = n_rise;
    wait_sig(1'b1, 1'b1, t1);
    check_cnt("zero_runs", 4, n_rise - t0);
    repeat (2 * TICK) @(posedge clk_sys);
    reg_rd(SUPMON_REG_ADDR, 8'h10, 8'h10);
    supply <= 4'h1;
    repeat (CONV) @(posedge clk_sys);
    check_byte("lvr_reset", 8'h01, {7'h00, lvr_reset});
    supply <= 4'h3;
    wait_sig(1'b1, 1'b0, t1);
    wait_sig(1'b0, 1'b0, t1);
    reg_rd(SUPMON_REG_ADDR, 8'hFF, 8'h23);
    reg_wr(8'h00);
    repeat (4) @(posedge clk_sys);
    give_verdict();
  end
endmodule : supmon_ctrl_tb
`default_nettype wire
